// ==== src/synth_regs_pkg.sv ====
// Constants, field layouts and carrier types for the synthesizer tuning and sync register bank
package synth_regs_pkg;

   // ==========================================================
   // Register addresses on the serial control port
   localparam logic [4:0]  ADDR_OUTPUT_CURRENT = 5'h03;
   localparam logic [4:0]  ADDR_AUTO_INTERVAL  = 5'h04;
   localparam logic [4:0]  ADDR_FREQUENCY      = 5'h07;
   localparam logic [4:0]  ADDR_PHASE          = 5'h08;
   localparam logic [4:0]  ADDR_AMPLITUDE      = 5'h09;
   localparam logic [4:0]  ADDR_SYNC           = 5'h0A;

   // ==========================================================
   // Buffered bank entries, index order
   localparam int          NUM_BANK  = 5;
   localparam int          IDX_CUR   = 0;
   localparam int          IDX_FREQ  = 1;
   localparam int          IDX_PHASE = 2;
   localparam int          IDX_AMP   = 3;
   localparam int          IDX_SYNC  = 4;

   localparam logic [NUM_BANK-1:0][4:0]  BANK_ADDR  = {ADDR_SYNC, ADDR_AMPLITUDE, ADDR_PHASE,
                                                       ADDR_FREQUENCY, ADDR_OUTPUT_CURRENT};
   localparam logic [31:0] RST_OUTPUT_CURRENT = 32'h0000007F;
   localparam logic [31:0] RST_AUTO_INTERVAL  = 32'h0FFFFFFF;
   localparam logic [31:0] RST_ZERO           = 32'h00000000;
   localparam logic [NUM_BANK-1:0][31:0] BANK_RESET = {RST_ZERO, RST_ZERO, RST_ZERO,
                                                       RST_ZERO, RST_OUTPUT_CURRENT};
   // Writable bits; open bits are masked off on write and read back as zero
   localparam logic [31:0] MASK_OUTPUT_CURRENT = 32'h000000FF;
   localparam logic [31:0] MASK_FULL           = 32'hFFFFFFFF;
   localparam logic [31:0] MASK_PHASE          = 32'h0000FFFF;
   localparam logic [31:0] MASK_SYNC           = 32'hFEFCF8F8;
   localparam logic [NUM_BANK-1:0][31:0] BANK_MASK  = {MASK_SYNC, MASK_FULL, MASK_PHASE,
                                                       MASK_FULL, MASK_OUTPUT_CURRENT};

   // ==========================================================
   // Field positions
   localparam int          AMP_RATE_LSB    = 16;
   localparam int          AMP_SCALE_LSB   = 2;
   localparam int          SYNC_VALDLY_LSB = 28;
   localparam int          SYNC_RXEN_BIT   = 27;
   localparam int          SYNC_GENEN_BIT  = 26;
   localparam int          SYNC_POL_BIT    = 25;
   localparam int          SYNC_PRESET_LSB = 18;
   localparam int          SYNC_OUTDLY_LSB = 11;
   localparam int          SYNC_INDLY_LSB  = 3;
   localparam logic [1:0]  KEYING_RAMP     = 2'h3;
   localparam int          DELAY_STEP_PS   = 75;

   // ==========================================================
   // Serial port framing
   localparam int          INSTR_READ_BIT  = 7;
   localparam logic [2:0]  LEN_WORD        = 3'h4;
   localparam logic [2:0]  LEN_HALF        = 3'h2;
   localparam logic [5:0]  INSTR_LAST_BIT  = 6'h07;

   typedef enum logic [1:0] {
      SP_IDLE  = 2'b00,
      SP_INSTR = 2'b01,
      SP_DATA  = 2'b10,
      SP_DONE  = 2'b11
   } serial_state_e;

   typedef struct packed {
      logic [15:0] ramp_rate;
      logic [13:0] scale;
      logic [1:0]  step;
   } amp_ctrl_s;

   typedef struct packed {
      logic [3:0]  validation_delay;
      logic        rx_enable;
      logic        gen_enable;
      logic        gen_polarity;
      logic [5:0]  preset;
      logic [4:0]  out_delay;
      logic [4:0]  in_delay;
   } sync_ctrl_s;

endpackage

// ==== src/serial_port_shift.sv ====
// Serial control port: pin synchronisers, instruction and data shifting
`timescale 1ns/1ps
module serial_port_shift
(
   input  wire logic        core_clk,
   input  wire logic        reset,
   input  wire logic        sclk_pin,
   input  wire logic        cs_n_pin,
   input  wire logic        sdio_pin,
   input  wire logic [31:0] rd_word,
   input  wire logic [2:0]  xfer_bytes,
   output logic [4:0]       addr,
   output logic [31:0]      wr_data,
   output logic             wr_strobe,
   output logic             sdo,
   output logic             sdo_oe_n
);
   import synth_regs_pkg::*;

   // ==========================================================
   // Pin synchronisers
   logic [1:0]  sclk_sync_ff, cs_sync_ff, sdio_sync_ff;
   logic        sclk_prev_ff;
   always_ff @(posedge core_clk)
   begin
      sclk_sync_ff <= {sclk_sync_ff[0], sclk_pin};
      cs_sync_ff   <= {cs_sync_ff[0], cs_n_pin};
      sdio_sync_ff <= {sdio_sync_ff[0], sdio_pin};
      sclk_prev_ff <= sclk_sync_ff[1];
   end

   wire         sclk_rise = sclk_sync_ff[1] & ~sclk_prev_ff;
   wire         sclk_fall = ~sclk_sync_ff[1] & sclk_prev_ff;
   wire         selected  = ~cs_sync_ff[1];

   // ==========================================================
   // Framing
   serial_state_e state_ff, nxt_state;
   logic [5:0]  cnt_ff;
   logic [31:0] shift_in_ff, shift_out_ff;
   logic        is_read_ff, load_ff, wr_strobe_ff;
   logic [4:0]  addr_ff;

   wire [5:0]   data_last = {xfer_bytes, 3'b000} - 6'h01;
   wire         instr_end = (state_ff == SP_INSTR) && sclk_rise && (cnt_ff == INSTR_LAST_BIT);
   wire         data_end  = (state_ff == SP_DATA) && sclk_rise && (cnt_ff == data_last);
   wire [31:0]  rd_aligned = (xfer_bytes == LEN_HALF) ? {rd_word[15:0], 16'h0000} : rd_word;

   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         SP_IDLE:  nxt_state = selected ? SP_INSTR : SP_IDLE;
         SP_INSTR: nxt_state = instr_end ? SP_DATA : SP_INSTR;
         SP_DATA:  nxt_state = data_end ? SP_DONE : SP_DATA;
         SP_DONE:  nxt_state = SP_DONE;
         default:  nxt_state = SP_IDLE;
      endcase
      if (!selected)
         nxt_state = SP_IDLE;
   end

   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         state_ff     <= SP_IDLE;
         cnt_ff       <= 6'h00;
         shift_in_ff  <= 32'h00000000;
         shift_out_ff <= 32'h00000000;
         is_read_ff   <= 1'b0;
         load_ff      <= 1'b0;
         wr_strobe_ff <= 1'b0;
         addr_ff      <= 5'h00;
      end
      else
      begin
         state_ff     <= nxt_state;
         load_ff      <= instr_end;
         wr_strobe_ff <= data_end & ~is_read_ff;
         if (state_ff == SP_IDLE || instr_end)
            cnt_ff <= 6'h00;
         else if (sclk_rise)
            cnt_ff <= cnt_ff + 6'h01;
         if (sclk_rise)
            shift_in_ff <= {shift_in_ff[30:0], sdio_sync_ff[1]};
         if (instr_end)
         begin
            addr_ff    <= {shift_in_ff[3:0], sdio_sync_ff[1]};
            is_read_ff <= shift_in_ff[INSTR_READ_BIT-1];
         end
         // Read data is loaded a cycle after the address settles so the mux output is stable
         if (load_ff)
            shift_out_ff <= rd_aligned;
         // The fall that closes the instruction must not shift, or the host loses the MSB
         else if (sclk_fall && state_ff == SP_DATA && cnt_ff != 6'h00)
            shift_out_ff <= {shift_out_ff[30:0], 1'b0};
      end
   end

   assign addr      = addr_ff;
   assign wr_data   = shift_in_ff;
   assign wr_strobe = wr_strobe_ff;
   assign sdo       = shift_out_ff[31];
   assign sdo_oe_n  = ~(is_read_ff && state_ff == SP_DATA);

endmodule // serial_port_shift

// ==== src/auto_update_timer.sv ====
// Interval counter that issues automatic transfer strobes
`timescale 1ns/1ps
module auto_update_timer
(
   input  wire logic        core_clk,
   input  wire logic        reset,
   input  wire logic        enable,
   input  wire logic [31:0] interval,
   output logic             update_pulse
);
   logic [31:0] count_ff;
   logic        pulse_ff;
   wire         expired = (count_ff >= interval);

   always_ff @(posedge core_clk)
   begin
      if (reset || !enable)
      begin
         count_ff <= 32'h00000000;
         pulse_ff <= 1'b0;
      end
      else
      begin
         count_ff <= expired ? 32'h00000000 : count_ff + 32'h00000001;
         pulse_ff <= expired;
      end
   end

   assign update_pulse = pulse_ff;

endmodule // auto_update_timer

// ==== src/synth_tuning_sync_regs.sv ====
// Tuning, amplitude, output-current and multichip sync register bank behind the serial port
//
// Notes on behaviour
// [R01] Output current code is eight bits in the low byte, reset 0x7F.
// [R02] Update-rate writes act at once, no transfer strobe needed.
// [R03] Update-rate value is ignored unless automatic update enable is one.
// [R04] Update-rate register is a 32-bit interval count, reset 0x0FFFFFFF.
// [R05] Frequency register bits 31..0 form one 32-bit tuning word.
// [R06] Phase register bits 15..0 form one 16-bit phase offset.
// [R07] Amplitude register bits 15..2 form a 14-bit scale value.
// [R08] Amplitude bits 31..16 are ramp rate, used only when keying field is 11.
// [R09] Amplitude bits 1..0 are step size, used only when keying field is 11.
// [R10] Sync bits 31..28 hold the 4-bit validation skew code, reset zero.
// [R11] Sync bit 27 enables the sync clock receiver, reset zero.
// [R12] Sync bit 26 enables the sync clock generator, reset zero.
// [R13] Sync bit 25 picks generated clock alignment, zero rising, one falling.
// [R14] A sync pulse loads the 6-bit preset from sync bits 23..18 while sync bit 27 (receiver enable) is one.
// [R15] Sync bits 15..11 hold the 5-bit generator output delay, reset zero.
// [R16] Sync bits 7..3 hold the 5-bit receiver input delay, reset zero.
// [R17] Open bits ignore writes and read back zero.
`timescale 1ns/1ps
module synth_tuning_sync_regs
(
   input  wire logic                      core_clk,
   input  wire logic                      reset,
   input  wire logic                      sclk,
   input  wire logic                      cs_n,
   input  wire logic                      sdio_in,
   output logic                           sdo,
   output logic                           sdo_oe_n,
   input  wire logic                      io_update_pin,
   input  wire logic                      sync_pulse_pin,
   input  wire logic                      auto_update_enable,
   input  wire logic [1:0]                keying_mode,
   output logic [7:0]                     full_scale_current_code,
   output logic [31:0]                    frequency_word,
   output logic [15:0]                    phase_word,
   output synth_regs_pkg::amp_ctrl_s      amplitude_control,
   output synth_regs_pkg::sync_ctrl_s     sync_control,
   output logic [5:0]                     sync_state,
   output logic                           sync_clk_out,
   output logic                           update_strobe
);
   import synth_regs_pkg::*;

   // ==========================================================
   // Serial port
   logic [4:0]  sp_addr;
   logic [31:0] sp_wr_data;
   logic        sp_wr_strobe;
   logic [31:0] rd_word;
   logic [31:0] rd_mask;
   logic [2:0]  xfer_bytes;

   serial_port_shift u_serial
   (
      .core_clk   (core_clk),
      .reset      (reset),
      .sclk_pin   (sclk),
      .cs_n_pin   (cs_n),
      .sdio_pin   (sdio_in),
      .rd_word    (rd_word),
      .xfer_bytes (xfer_bytes),
      .addr       (sp_addr),
      .wr_data    (sp_wr_data),
      .wr_strobe  (sp_wr_strobe),
      .sdo        (sdo),
      .sdo_oe_n   (sdo_oe_n)
   );

   // The phase register is the only two-byte frame; unmapped addresses take four bytes
   assign xfer_bytes = (sp_addr == ADDR_PHASE) ? LEN_HALF : LEN_WORD;

   // ==========================================================
   // Pin synchronisers for the transfer strobe and the sync pulse
   logic [1:0]  update_sync_ff;
   logic [1:0]  syncp_sync_ff;
   logic        update_prev_ff;
   logic        syncp_prev_ff;
   always_ff @(posedge core_clk)
   begin
      update_sync_ff <= {update_sync_ff[0], io_update_pin};
      syncp_sync_ff  <= {syncp_sync_ff[0], sync_pulse_pin};
      update_prev_ff <= update_sync_ff[1];
      syncp_prev_ff  <= syncp_sync_ff[1];
   end

   wire         pin_update = update_sync_ff[1] & ~update_prev_ff;
   wire         sync_edge  = syncp_sync_ff[1] & ~syncp_prev_ff;

   // ==========================================================
   // Automatic update interval, applied directly without buffering
   logic [31:0] interval_ff;
   logic        timer_pulse;
   wire         interval_hit = sp_wr_strobe && (sp_addr == ADDR_AUTO_INTERVAL);

   always_ff @(posedge core_clk)
   begin
      if (reset)
         interval_ff <= RST_AUTO_INTERVAL;    // R04
      else if (interval_hit)
         interval_ff <= sp_wr_data;           // R02
   end

   auto_update_timer u_timer
   (
      .core_clk     (core_clk),
      .reset        (reset),
      .enable       (auto_update_enable),     // R03
      .interval     (interval_ff),            // R04
      .update_pulse (timer_pulse)
   );

   // Either the pin strobe or the timer moves buffered contents into the active set
   wire         transfer = pin_update | timer_pulse;

   // ==========================================================
   // Buffered and active bank entries
   logic [NUM_BANK-1:0][31:0] buf_ff;
   logic [NUM_BANK-1:0][31:0] act_ff;
   logic [NUM_BANK:0][31:0]   rd_chain;
   logic [NUM_BANK:0][31:0]   mask_chain;

   assign rd_chain[0]   = (sp_addr == ADDR_AUTO_INTERVAL) ? interval_ff : 32'h00000000;
   assign mask_chain[0] = (sp_addr == ADDR_AUTO_INTERVAL) ? MASK_FULL : 32'h00000000;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_BANK; gi = gi + 1)
      begin : g_bank
         wire sel    = (sp_addr == BANK_ADDR[gi]);
         wire wr_hit = sp_wr_strobe && sel;

         always_ff @(posedge core_clk)
         begin
            if (reset)
            begin
               buf_ff[gi] <= BANK_RESET[gi];                       // R01
               act_ff[gi] <= BANK_RESET[gi];
            end
            else
            begin
               if (wr_hit)
                  buf_ff[gi] <= sp_wr_data & BANK_MASK[gi];        // R17
               if (transfer)
                  act_ff[gi] <= buf_ff[gi];
            end
         end

         assign rd_chain[gi+1]   = rd_chain[gi] | (sel ? buf_ff[gi] : 32'h00000000);
         assign mask_chain[gi+1] = mask_chain[gi] | (sel ? BANK_MASK[gi] : 32'h00000000);
      end
   endgenerate

   // Unmapped addresses read as zero
   assign rd_word = rd_chain[NUM_BANK];
   assign rd_mask = mask_chain[NUM_BANK];

   // ==========================================================
   // Field extraction from the active set
   wire [31:0]  amp_act   = act_ff[IDX_AMP];
   wire [31:0]  sync_act  = act_ff[IDX_SYNC];
   wire         ramp_mode = (keying_mode == KEYING_RAMP);

   assign full_scale_current_code = act_ff[IDX_CUR][7:0];                       // R01
   assign frequency_word          = act_ff[IDX_FREQ];                           // R05
   assign phase_word              = act_ff[IDX_PHASE][15:0];                    // R06

   amp_ctrl_s   amp_out_ff;
   always_ff @(posedge core_clk)
   begin
      if (reset)
         amp_out_ff <= '0;
      else
      begin
         amp_out_ff.scale     <= amp_act[AMP_SCALE_LSB +: 14];                  // R07
         // Ramp parameters are forced to zero outside ramped keying
         amp_out_ff.ramp_rate <= ramp_mode ? amp_act[AMP_RATE_LSB +: 16] : 16'h0000;  // R08
         amp_out_ff.step      <= ramp_mode ? amp_act[1:0] : 2'h0;               // R09
      end
   end
   assign amplitude_control = amp_out_ff;

   assign sync_control.validation_delay = sync_act[SYNC_VALDLY_LSB +: 4];       // R10
   assign sync_control.rx_enable        = sync_act[SYNC_RXEN_BIT];              // R11
   assign sync_control.gen_enable       = sync_act[SYNC_GENEN_BIT];             // R12
   assign sync_control.gen_polarity     = sync_act[SYNC_POL_BIT];               // R13
   assign sync_control.preset           = sync_act[SYNC_PRESET_LSB +: 6];       // R14
   assign sync_control.out_delay        = sync_act[SYNC_OUTDLY_LSB +: 5];       // R15
   assign sync_control.in_delay         = sync_act[SYNC_INDLY_LSB +: 5];        // R16

   // ==========================================================
   // Internal sync clock generator state
   // The falling-edge option is modelled as an inversion; true half-cycle timing is analog
   logic [5:0]  sync_state_ff;
   logic        sync_clk_ff;
   logic        update_strobe_ff;
   wire         preset_load = sync_edge && sync_control.rx_enable;

   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         sync_state_ff    <= 6'h00;
         sync_clk_ff      <= 1'b0;
         update_strobe_ff <= 1'b0;
      end
      else
      begin
         update_strobe_ff <= transfer;
         if (preset_load)
            sync_state_ff <= sync_control.preset;                               // R14
         else if (sync_control.gen_enable)
            sync_state_ff <= sync_state_ff + 6'h01;
         sync_clk_ff <= sync_control.gen_enable & (sync_state_ff[5] ^ sync_control.gen_polarity);  // R13
      end
   end

   assign sync_state    = sync_state_ff;
   assign sync_clk_out  = sync_clk_ff;
   assign update_strobe = update_strobe_ff;

   // ==========================================================
   // Checks
   AST_CURRENT_RESET: assert property (@(posedge core_clk) disable iff (reset)   // R01
      $fell(reset) |-> (full_scale_current_code == RST_OUTPUT_CURRENT[7:0]))
      else $error("output current code not at reset default");

   AST_INTERVAL_IMMEDIATE: assert property (@(posedge core_clk) disable iff (reset)   // R02
      (interval_hit && !transfer) |=> (interval_ff == $past(sp_wr_data)))
      else $error("update interval write did not apply at once");

   AST_TIMER_GATED: assert property (@(posedge core_clk) disable iff (reset)   // R03
      !auto_update_enable |=> !timer_pulse)
      else $error("automatic update fired while disabled");

   AST_INTERVAL_RESET: assert property (@(posedge core_clk) disable iff (reset)   // R04
      $fell(reset) |-> (interval_ff == RST_AUTO_INTERVAL))
      else $error("update interval not at reset default");

   AST_FREQ_TRANSFER: assert property (@(posedge core_clk) disable iff (reset)   // R05
      transfer |=> (frequency_word == $past(buf_ff[IDX_FREQ])))
      else $error("frequency word not transferred");

   AST_PHASE_HOLD: assert property (@(posedge core_clk) disable iff (reset)   // R06
      !transfer |=> $stable(phase_word))
      else $error("phase word changed without transfer");

   AST_SCALE_FOLLOW: assert property (@(posedge core_clk) disable iff (reset)   // R07
      transfer ##1 !transfer |=> (amplitude_control.scale == $past(amp_act[15:2])))
      else $error("amplitude scale does not follow register");

   AST_RAMP_GATED: assert property (@(posedge core_clk) disable iff (reset)   // R08
      !ramp_mode |=> (amplitude_control.ramp_rate == 16'h0000))
      else $error("ramp rate passed outside ramped keying");

   AST_STEP_GATED: assert property (@(posedge core_clk) disable iff (reset)   // R09
      ramp_mode |=> (amplitude_control.step == $past(amp_act[1:0])))
      else $error("step size not passed in ramped keying");

   AST_SYNC_PRESET: assert property (@(posedge core_clk) disable iff (reset)   // R14
      preset_load |=> (sync_state == $past(sync_control.preset)))
      else $error("sync state did not load preset");

   AST_OPEN_BITS_ZERO: assert property (@(posedge core_clk) disable iff (reset)   // R17
      (rd_word & ~rd_mask) == 32'h00000000)
      else $error("open bit reads nonzero");

endmodule // synth_tuning_sync_regs

// ==== verif/test_synth_tuning_sync_regs.sv ====
// Self-checking bench for the tuning and sync register bank
`timescale 1ns/1ps
module test_synth_tuning_sync_regs;
   import synth_regs_pkg::*;
   // ==========================================================
   // Stimulus and observed signals
   logic        core_clk = 1'b0;
   logic        reset = 1'b1;
   logic        sclk = 1'b0;
   logic        cs_n = 1'b1;
   logic        sdio_in = 1'b0;
   logic        io_update_pin = 1'b0;
   logic        sync_pulse_pin = 1'b0;
   logic        auto_update_enable = 1'b0;
   logic [1:0]  keying_mode = 2'h3;
   logic        sdo;
   logic        sdo_oe_n;
   logic        sync_clk_out;
   logic        update_strobe;
   logic [7:0]  full_scale_current_code;
   logic [31:0] frequency_word;
   logic [15:0] phase_word;
   amp_ctrl_s   amplitude_control;
   sync_ctrl_s  sync_control;
   logic [5:0]  sync_state;
   logic [31:0] rd;
   int          n;
   int          cycles = 0;
   int          error_cnt = 0;
   int          num_checks = 0;

   typedef struct packed {logic [4:0] a; logic [31:0] w; logic [31:0] rb; logic [31:0] rst;} row_s;
   // Write value, expected readback (also the active value after a transfer), value before it
   row_s rows [6] = '{
      '{ADDR_OUTPUT_CURRENT, 32'hFFFFFFA5, 32'h000000A5, 32'h0000007F},
      '{ADDR_FREQUENCY,      32'h89ABCDEF, 32'h89ABCDEF, 32'h00000000},
      '{ADDR_PHASE,          32'hABCD1234, 32'h00001234, 32'h00000000},
      '{ADDR_AMPLITUDE,      32'hDEADBEEF, 32'hDEADBEEF, 32'h00000000},
      '{ADDR_SYNC,           32'hFFFFFFFF, 32'hFEFCF8F8, 32'h00000000},
      '{5'h05,               32'hFFFFFFFF, 32'h00000000, 32'h00000000}};

   synth_tuning_sync_regs i_dut (
      .core_clk(core_clk), .reset(reset), .sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_in), .sdo(sdo),
      .sdo_oe_n(sdo_oe_n), .io_update_pin(io_update_pin), .sync_pulse_pin(sync_pulse_pin),
      .auto_update_enable(auto_update_enable), .keying_mode(keying_mode),
      .full_scale_current_code(full_scale_current_code), .frequency_word(frequency_word),
      .phase_word(phase_word), .amplitude_control(amplitude_control), .sync_control(sync_control),
      .sync_state(sync_state), .sync_clk_out(sync_clk_out), .update_strobe(update_strobe));

   always #20 core_clk = ~core_clk;

   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         error_cnt++;
         end_of_test();
      end
   end

   // ==========================================================
   // Tasks
   task automatic tick(input int k);
      repeat (k) @(posedge core_clk);
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Four cycles low and four high per bit so the pin synchroniser sees every level
   task automatic bitx(input logic b, inout logic [31:0] r);
      sdio_in <= b;
      tick(3);
      @(negedge core_clk);
      r = {r[30:0], sdo};
      @(posedge core_clk);
      sclk <= 1'b1;
      tick(4);
      sclk <= 1'b0;
   endtask

   task automatic frame(input logic [7:0] ins, input logic [31:0] d, input int nb, output logic [31:0] r);
      r = '0;
      cs_n <= 1'b0;
      tick(4);
      for (int i = 7; i >= 0; i--)
         bitx(ins[i], r);
      for (int i = nb - 1; i >= 0; i--)
         bitx(d[i], r);
      tick(4);
      cs_n <= 1'b1;
      tick(8);
   endtask

   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      frame({3'h0, a}, d, (a == ADDR_PHASE) ? 16 : 32, rd);
   endtask

   task automatic rdx(input logic [4:0] a, input logic [31:0] exp);
      frame({3'h4, a}, 32'h0, (a == ADDR_PHASE) ? 16 : 32, rd);
      chk(rd & ((a == ADDR_PHASE) ? 32'h0000FFFF : 32'hFFFFFFFF), exp);
   endtask

   task automatic transfer;
      io_update_pin <= 1'b1;
      tick(4);
      io_update_pin <= 1'b0;
      tick(4);
   endtask

   task automatic count(input int len, output int c);
      c = 0;
      repeat (len)
      begin
         @(negedge core_clk);
         c += int'(update_strobe === 1'b1);
      end
   endtask

   function automatic logic [31:0] active(input logic [4:0] a);
      case (a)
         ADDR_OUTPUT_CURRENT: return {24'h0, full_scale_current_code};
         ADDR_FREQUENCY:      return frequency_word;
         ADDR_PHASE:          return {16'h0, phase_word};
         ADDR_AMPLITUDE:      return amplitude_control;
         ADDR_SYNC:           return {sync_control.validation_delay, sync_control.rx_enable,
                                      sync_control.gen_enable, sync_control.gen_polarity, 1'b0,
                                      sync_control.preset, 2'h0, sync_control.out_delay, 3'h0,
                                      sync_control.in_delay, 3'h0};
         default:             return 32'h0;
      endcase
   endfunction

   task automatic end_of_test;
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // ==========================================================
   // Sequence
   initial
   begin
      tick(4);
      reset <= 1'b0;
      tick(4);
      foreach (rows[i])
      begin
         wr(rows[i].a, rows[i].w);
         rdx(rows[i].a, rows[i].rb);
         chk(active(rows[i].a), rows[i].rst);
         transfer();
         chk(active(rows[i].a), rows[i].rb);
      end
      keying_mode <= 2'h0;
      tick(3);
      chk(amplitude_control, 32'h0000BEEC);
      // Interval takes effect with no transfer; strobes only while enabled
      wr(ADDR_AUTO_INTERVAL, 32'h0000000A);
      rdx(ADDR_AUTO_INTERVAL, 32'h0000000A);
      count(40, n);
      chk(32'(n), 32'h0);
      auto_update_enable <= 1'b1;
      tick(6);
      count(44, n);
      chk(32'(n), 32'h4);
      auto_update_enable <= 1'b0;
      reset <= 1'b1;
      tick(4);
      reset <= 1'b0;
      tick(4);
      rdx(ADDR_AUTO_INTERVAL, 32'h0FFFFFFF);
      rdx(ADDR_OUTPUT_CURRENT, 32'h0000007F);
      chk(active(ADDR_SYNC), 32'h0);
      // Frame cut short by the select going high must leave the register alone
      frame({3'h0, ADDR_FREQUENCY}, 32'h0000FFFF, 16, rd);
      rdx(ADDR_FREQUENCY, 32'h0);
      wr(ADDR_SYNC, 32'h08A80000);
      transfer();
      sync_pulse_pin <= 1'b1;
      tick(5);
      sync_pulse_pin <= 1'b0;
      tick(2);
      chk({26'h0, sync_state}, 32'h0000002A);
      chk({31'h0, sync_clk_out}, 32'h0);
      end_of_test();
   end
endmodule // test_synth_tuning_sync_regs
